//--- core/flash_seq_pkg.sv
/*
 * Shared constants for the flash command sequencer: bus sequence keys,
 * control field codes, identification addresses and operation timing.
 * Assumes a 50 MHz system clock and a byte-wide CPU bus.
 */
// Operation
// - Chip erase finishes within 30 ms
// - Erased bytes read back as all ones
// - No new sequence while erase runs
// - Bit 6 inverts each read while busy
// - First read after command toggles to one
// - Disabled program mode stops the toggling
// - Poll toggle with single byte reads only
// - Slow clock byte write finishes before read
// - Identification mode returns vendor, flash, security
// - Security byte all ones when unprotected
// - Identification exit restores array reads
// - Protection blocks parallel reads, serial loaders
// - Only chip erase clears protection (reset also clears it)
// - Protection change within 40 us, blocks
// - Busy blocks all flash reads and fetches
// - Byte access, sector or chip erase
// - Read one access, writes need sequences
// - No reset during busy operations
// - Enable: mode 101, area, commit key
// - Disable: mode 010, then commit key
// - Poll pairs of reads until equal
package flash_seq_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          SECT_W        = 4;
    localparam logic [15:0] KEY_ADDR_A    = 16'hF555;
    localparam logic [15:0] KEY_ADDR_B    = 16'hFAAA;
    localparam logic [7:0]  KEY_DATA_A    = 8'hAA;
    localparam logic [7:0]  KEY_DATA_B    = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
    localparam logic [7:0]  CMD_ERASE_PRE = 8'h80;
    localparam logic [7:0]  CMD_SECTOR    = 8'h30;
    localparam logic [7:0]  CMD_CHIP      = 8'h10;
    localparam logic [7:0]  CMD_ID_ENTRY  = 8'h90;
    localparam logic [7:0]  CMD_ID_EXIT   = 8'hF0;
    localparam logic [7:0]  CMD_SECURITY  = 8'hA5;
    localparam logic [2:0]  MODE_ENABLE   = 3'h5;
    localparam logic [2:0]  MODE_DISABLE  = 3'h2;
    localparam logic [7:0]  COMMIT_KEY    = 8'hD5;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
    localparam logic [15:0] ID_VENDOR_ADR = 16'hF000;
    localparam logic [15:0] ID_FLASH_ADR  = 16'hF001;
    localparam logic [15:0] ID_SECUR_ADR  = 16'hFF7F;
    localparam logic [7:0]  SECUR_OFF     = 8'hFF;
    localparam logic [7:0]  SECUR_ON      = 8'h00;
    localparam int          TOGGLE_BIT    = 6;
    localparam int          CLK_MHZ       = 50;
    localparam int          ERASE_MS      = 30;
    localparam int          SECUR_US      = 40;
    localparam int          PROG_US       = 40;
    localparam int          ERASE_CYC     = ERASE_MS * 1000 * CLK_MHZ;
    localparam int          SECUR_CYC     = SECUR_US * CLK_MHZ;
    localparam int          PROG_CYC      = PROG_US * CLK_MHZ;
    localparam int          CNT_W         = 21;
endpackage

//--- core/flash_seq_if.sv
/*
 * Byte bus between the CPU-side sequencer and the flash controller.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface flash_seq_if;
    logic        wr;        // One-cycle write strobe
    logic        rd;        // One-cycle read strobe
    logic        wide;      // Read is a 16-bit transfer
    logic [15:0] addr;      // Byte address
    logic [7:0]  wdata;     // Write data
    logic [7:0]  rdata;     // Read data
    logic        rvalid;    // Read data valid pulse
    logic        cw_wr;     // Control register write
    logic        cw_sel;    // 0 primary control, 1 commit
    logic [7:0]  cw_data;   // Control write data
    modport ctrl (input wr, rd, wide, addr, wdata, cw_wr, cw_sel, cw_data,
                  output rdata, rvalid);
    modport cpu (output wr, rd, wide, addr, wdata, cw_wr, cw_sel, cw_data,
                 input rdata, rvalid);
endinterface

//--- core/flash_seq_ctrl.sv
/*
 * Flash command controller: decodes bus write sequences, runs erase,
 * program and protection operations, serves identification reads.
 * Assumes the CPU runs from RAM while an operation is busy.
 */
`timescale 1ns/1ps
module flash_seq_ctrl #(
    parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYC,
    parameter logic [7:0] VENDOR_CODE = 8'h3C,  // Arbitrary value
    parameter logic [7:0] FLASH_CODE  = 8'h5A   // Arbitrary value
) (
    input  wire logic   i_clock,        // System clock
    input  wire logic   i_rst,          // Synchronous reset
    flash_seq_if.ctrl   bus,            // CPU byte bus
    input  wire logic   i_slow_mode,    // Slow clock mode
    input  wire logic   i_par_prog,     // Parallel programmer mode
    input  wire logic   i_ser_overwr,   // Serial overwrite request
    output logic        o_busy,         // Operation in progress
    output logic        o_protected,    // Protection enabled
    output logic        o_ser_reject,   // Serial loader command refused
    output logic        o_id_mode       // Identification mode active
);
    import flash_seq_pkg::*;

    // Write-sequence position
    typedef enum logic [2:0] {S_IDLE, S_K1, S_K2, S_E3, S_E4, S_E5} seq_e;
    seq_e seq_q;

    // Array has no reset by design
    logic [7:0]  mem_q [0:65535];
    logic [2:0]  mode_pend_q, mode_q;
    logic [1:0]  op_q;                 // 0 prog, 1 sector, 2 chip, 3 security

    // Latched operation
    logic [15:0] op_addr_q;
    logic [7:0]  op_data_q;
    logic [CNT_W-1:0] cnt_q;

    // Status flags
    logic        busy_q, prot_q, id_q, tog_q, rej_q;

    // Read answer
    logic [7:0]  rdata_q;
    logic        rvalid_q;

    // Busy length per operation
    function automatic logic [CNT_W-1:0] op_len(input logic [1:0] op, input logic slow);
        if (op == 2'd0) op_len = slow ? CNT_W'(1) : CNT_W'(PROG_CYC);
        else if (op == 2'd3) op_len = CNT_W'(SECUR_CYC);
        else op_len = CNT_W'(ERASE_CYCLES);
    endfunction

    // Decode of the incoming write in light of the key state
    wire enabled  = (mode_q == MODE_ENABLE);
    wire key_a    = bus.wr && bus.addr == KEY_ADDR_A && bus.wdata == KEY_DATA_A;
    wire key_b    = bus.wr && bus.addr == KEY_ADDR_B && bus.wdata == KEY_DATA_B;
    wire cmd_wr   = bus.wr && bus.addr == KEY_ADDR_A;
    wire can_seq  = enabled && !busy_q;
    // Final write starts the work
    wire start_op = bus.wr && !busy_q && enabled &&
                    ((seq_q == S_E5) || (seq_q == S_E3 && op_q == 2'd0));
    // Identification read data
    wire [15:0] id_sel_addr = bus.addr;
    wire [7:0]  id_data = (id_sel_addr == ID_VENDOR_ADR) ? VENDOR_CODE :
                          (id_sel_addr == ID_FLASH_ADR)  ? FLASH_CODE  :
                          (id_sel_addr == ID_SECUR_ADR)  ?
                          (prot_q ? SECUR_ON : SECUR_OFF) : ERASED_BYTE;

    // Pending disable already stops it
    wire tog_en = (mode_pend_q != MODE_DISABLE) && (mode_q != MODE_DISABLE);

    // Control registers: sequence enable takes effect only on the commit key
    // Pending mode acts on commit
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_pend_q <= MODE_DISABLE;
            mode_q      <= MODE_DISABLE;
        end else if (bus.cw_wr && !bus.cw_sel) begin
            mode_pend_q <= bus.cw_data[7:5];
        end else if (bus.cw_wr && bus.cw_sel && bus.cw_data == COMMIT_KEY) begin
            mode_q <= mode_pend_q;
        end
    end

    // Command sequence walker; ignored while busy
    // Disabled writes are dropped
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            seq_q     <= S_IDLE;
            op_q      <= 2'd0;
            op_addr_q <= '0;
            op_data_q <= '0;
            id_q      <= 1'b0;
        end else if (bus.wr && can_seq) begin
            case (seq_q)
                S_IDLE: seq_q <= key_a ? S_K1 : S_IDLE;
                S_K1:   seq_q <= key_b ? S_K2 : S_IDLE;
                S_K2: begin
                    seq_q <= S_IDLE;
                    if (cmd_wr && bus.wdata == CMD_PROGRAM) begin
                        seq_q <= S_E3;
                        op_q  <= 2'd0;
                    end else if (cmd_wr && bus.wdata == CMD_ERASE_PRE) begin
                        seq_q <= S_E3;
                        op_q  <= 2'd1;
                    end else if (cmd_wr && bus.wdata == CMD_ID_ENTRY) begin
                        id_q <= 1'b1;
                    end else if (cmd_wr && bus.wdata == CMD_ID_EXIT) begin
                        id_q <= 1'b0;
                    end else if (cmd_wr && bus.wdata == CMD_SECURITY) begin
                        seq_q <= S_E3;
                        op_q  <= 2'd3;
                    end
                end
                S_E3: begin
                    op_addr_q <= bus.addr;
                    op_data_q <= bus.wdata;
                    seq_q <= (op_q == 2'd0) ? S_IDLE : (key_a ? S_E4 : S_IDLE);
                end
                S_E4:   seq_q <= key_b ? S_E5 : S_IDLE;
                S_E5: begin
                    seq_q     <= S_IDLE;
                    op_addr_q <= bus.addr;
                    if (op_q != 2'd3)
                        op_q <= (bus.wdata == CMD_CHIP) ? 2'd2 : 2'd1;
                end
                default: seq_q <= S_IDLE;
            endcase
        end
    end

    // Busy timer: one internal state covers every long operation
    // Reloads only from idle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (start_op) begin
            busy_q <= 1'b1;
            cnt_q  <= op_len(seq_q == S_E3 ? 2'd0 : op_q, i_slow_mode);
        end else if (busy_q) begin
            cnt_q  <= cnt_q - CNT_W'(1);
            busy_q <= (cnt_q > CNT_W'(1));
        end
    end

    // Array contents and protection change when the operation ends
    wire finish = busy_q && cnt_q == CNT_W'(1);

    // Only chip erase or reset clears it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            prot_q <= 1'b0;
        end else if (finish) begin
            if (op_q == 2'd3) prot_q <= 1'b1;
            else if (op_q == 2'd2) prot_q <= 1'b0;
        end
    end

    // Storage update: program ANDs bits, erase sets bytes to ones
    // Programming only clears bits
    always_ff @(posedge i_clock) begin
        if (finish) begin
            for (int i = 0; i < 65536; i++) begin
                if (op_q == 2'd2 ||
                    (op_q == 2'd1 && i[15:12] == op_addr_q[15:12]))
                    mem_q[i] <= ERASED_BYTE;
            end
            if (op_q == 2'd0)
                mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
        end
    end

    // Read path with blocking and toggle status
    // Toggle restarts at each start
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tog_q    <= 1'b0;
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            rej_q    <= 1'b0;
        end else begin
            rvalid_q <= bus.rd;
            rej_q    <= prot_q && i_ser_overwr;
            if (start_op) tog_q <= 1'b0;
            if (bus.rd) begin
                if (busy_q) begin
                    rdata_q <= 8'h00;
                    rdata_q[TOGGLE_BIT] <= tog_en ? !tog_q : tog_q;
                    if (tog_en) tog_q <= !tog_q;
                end else if (prot_q && i_par_prog) begin
                    rdata_q <= 8'h00;
                end else if (id_q) begin
                    rdata_q <= id_data;
                end else begin
                    rdata_q <= mem_q[bus.addr];
                end
            end
        end
    end

    // Outputs straight from flops
    assign bus.rdata   = rdata_q;
    assign bus.rvalid  = rvalid_q;
    assign o_busy      = busy_q;
    assign o_protected = prot_q;
    assign o_ser_reject = rej_q;
    assign o_id_mode   = id_q;
endmodule

//--- core/flash_seq_cpu.sv
/*
 * CPU-side sequencer: turns one user command into the control writes,
 * bus write sequence and toggle polling that the controller expects.
 * Assumes the controller answers every read one cycle later.
 */
`timescale 1ns/1ps
module flash_seq_cpu (
    input  wire logic        i_clock,   // System clock
    input  wire logic        i_rst,     // Synchronous reset
    input  wire logic        i_start,   // Start pulse
    input  wire logic [2:0]  i_cmd,     // 0 prog 1 sector 2 chip 3 sec 4 id-in 5 id-out
    input  wire logic [15:0] i_addr,    // Target address
    input  wire logic [7:0]  i_data,    // Program data
    output logic             o_done,    // Done pulse
    output logic             o_busy,    // Sequencer active
    flash_seq_if.cpu         bus        // Controller bus
);
    import flash_seq_pkg::*;

    typedef enum logic [2:0] {C_IDLE, C_EN, C_COMMIT, C_WR, C_POLL, C_DIS, C_END} cst_e;
    cst_e st_q;
    logic [2:0]  idx_q, cmd_q;
    logic [15:0] addr_q;
    logic [7:0]  data_q, prev_q;
    logic        have_q, en_q, done_q, act_q;
    logic        wr_q, rd_q, cw_q, sel_q;
    logic [15:0] baddr_q;
    logic [7:0]  bdata_q, cwd_q;

    // Write steps of each command sequence
    wire [2:0] nsteps = (i_cmd_is(cmd_q, 3'd0)) ? 3'd4 :
                        (cmd_q == 3'd1 || cmd_q == 3'd2) ? 3'd6 :
                        (cmd_q == 3'd3) ? 3'd6 : 3'd3;
    wire [7:0] step3 = (cmd_q == 3'd0) ? CMD_PROGRAM :
                       (cmd_q == 3'd4) ? CMD_ID_ENTRY :
                       (cmd_q == 3'd5) ? CMD_ID_EXIT :
                       (cmd_q == 3'd3) ? CMD_SECURITY : CMD_ERASE_PRE;
    wire [7:0] step6 = (cmd_q == 3'd2) ? CMD_CHIP : CMD_SECTOR;
    wire waits = (cmd_q <= 3'd3);

    function automatic logic i_cmd_is(input logic [2:0] c, input logic [2:0] v);
        i_cmd_is = (c == v);
    endfunction

    // Sequencer: enable, keyed writes, poll, disable
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_q <= C_IDLE; idx_q <= '0; cmd_q <= '0; addr_q <= '0; data_q <= '0;
            prev_q <= '0; have_q <= 1'b0; en_q <= 1'b0; done_q <= 1'b0;
            act_q <= 1'b0;
            wr_q <= 1'b0; rd_q <= 1'b0; cw_q <= 1'b0; sel_q <= 1'b0;
            baddr_q <= '0; bdata_q <= '0; cwd_q <= '0;
        end else begin
            wr_q <= 1'b0; rd_q <= 1'b0; cw_q <= 1'b0; done_q <= 1'b0;
            case (st_q)
                C_IDLE: if (i_start) begin
                    cmd_q <= i_cmd; addr_q <= i_addr; data_q <= i_data;
                    idx_q <= '0; en_q <= 1'b1; st_q <= C_EN;
                    act_q <= 1'b1;
                end
                C_EN: begin
                    cw_q <= 1'b1; sel_q <= 1'b0;
                    cwd_q <= {en_q ? MODE_ENABLE : MODE_DISABLE, 5'h00};
                    st_q <= C_COMMIT;
                end
                C_COMMIT: begin
                    cw_q <= 1'b1; sel_q <= 1'b1; cwd_q <= COMMIT_KEY;
                    st_q <= en_q ? C_WR : C_END;
                end
                C_WR: begin
                    wr_q <= 1'b1;
                    case (idx_q)
                        3'd0, 3'd3: begin baddr_q <= KEY_ADDR_A; bdata_q <= KEY_DATA_A; end
                        3'd1, 3'd4: begin baddr_q <= KEY_ADDR_B; bdata_q <= KEY_DATA_B; end
                        3'd2: begin baddr_q <= KEY_ADDR_A; bdata_q <= step3; end
                        default: begin
                            baddr_q <= addr_q;
                            bdata_q <= (cmd_q == 3'd0) ? data_q : step6;
                        end
                    endcase
                    if (cmd_q == 3'd0 && idx_q == 3'd2) idx_q <= 3'd5;
                    else idx_q <= idx_q + 3'd1;
                    if (idx_q + 3'd1 == nsteps || (cmd_q == 3'd0 && idx_q == 3'd5)) begin
                        have_q <= 1'b0;
                        st_q <= waits ? C_POLL : C_DIS;
                    end
                end
                C_POLL: begin
                    if (!rd_q && !bus.rvalid) begin
                        rd_q <= 1'b1; baddr_q <= addr_q;
                    end
                    if (bus.rvalid) begin
                        prev_q <= bus.rdata; have_q <= 1'b1;
                        if (have_q && bus.rdata == prev_q) st_q <= C_DIS;
                    end
                end
                C_DIS: begin en_q <= 1'b0; st_q <= C_EN; end
                C_END: begin done_q <= 1'b1; act_q <= 1'b0; st_q <= C_IDLE; end
                default: st_q <= C_IDLE;
            endcase
        end
    end

    assign bus.wr      = wr_q;
    assign bus.rd      = rd_q;
    assign bus.wide    = 1'b0;
    assign bus.addr    = baddr_q;
    assign bus.wdata   = bdata_q;
    assign bus.cw_wr   = cw_q;
    assign bus.cw_sel  = sel_q;
    assign bus.cw_data = cwd_q;
    assign o_done      = done_q;
    assign o_busy      = act_q;
endmodule

//--- testbench/flash_seq_properties.sv
/*
 * Concurrent checks on the bus joining the CPU sequencer and controller.
 * Assumes one clock and a synchronous, active-high reset.
 */
`timescale 1ns/1ps
module flash_seq_properties #(
    parameter int ERASE_CYCLES = 50
) (
    input wire logic        i_clock,      // System clock
    input wire logic        i_rst,        // Reset
    input wire logic        wr,           // Write strobe
    input wire logic        rd,           // Read strobe
    input wire logic        wide,         // Wide read
    input wire logic [15:0] addr,         // Address
    input wire logic [7:0]  wdata,        // Write data
    input wire logic [7:0]  rdata,        // Read data
    input wire logic        rvalid,       // Read valid
    input wire logic        cw_wr,        // Control write
    input wire logic        cw_sel,       // Commit select
    input wire logic [7:0]  cw_data,      // Control data
    input wire logic        o_busy,       // Controller busy
    input wire logic        o_protected,  // Protection on
    input wire logic        i_ser_overwr, // Loader request
    input wire logic        o_ser_reject  // Loader refused
);
    import flash_seq_pkg::*;
    localparam int LIMIT = (ERASE_CYCLES > SECUR_CYC ? ERASE_CYCLES : SECUR_CYC) + 4;
    logic        busy_q;
    logic        rb_q;
    logic        tog_q;
    logic [31:0] cnt_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Toggle tracking restarts at each busy rise, so first poll must read one
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            rb_q   <= 1'b0;
            tog_q  <= 1'b0;
            cnt_q  <= 32'h0000_0000;
        end else begin
            busy_q <= o_busy;
            rb_q   <= rd && o_busy;
            cnt_q  <= o_busy ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
            if (o_busy && !busy_q) begin
                tog_q <= 1'b0;
            end else if (rvalid && rb_q) begin
                tog_q <= rdata[TOGGLE_BIT];
            end
        end
    end

    a_read_answer: assert property (rd |=> rvalid)
        else $error("read not answered");
    a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
        else $error("read data moved");
    a_narrow_poll: assert property (rd |-> !wide)
        else $error("wide poll read");
    a_commit_key: assert property (cw_wr && cw_sel |-> cw_data == COMMIT_KEY)
        else $error("bad commit key");
    a_mode_code: assert property (cw_wr && !cw_sel |->
        cw_data[7:5] == MODE_ENABLE || cw_data[7:5] == MODE_DISABLE)
        else $error("bad mode code");
    a_key_second: assert property (wr && addr == KEY_ADDR_B |-> wdata == KEY_DATA_B)
        else $error("bad second key");
    a_busy_blank: assert property (rd && o_busy |=> (rdata & 8'hBF) == 8'h00)
        else $error("array seen while busy");
    a_toggle_flip: assert property (rvalid && rb_q |-> rdata[TOGGLE_BIT] != tog_q)
        else $error("toggle bit wrong");
    a_ser_reject: assert property (1'b1 |=>
        o_ser_reject == ($past(i_ser_overwr) && $past(o_protected)))
        else $error("loader refusal wrong");
    a_busy_bound: assert property (cnt_q <= LIMIT)
        else $error("operation too long");

    // Main scenarios reached
    c_op_end: cover property ($fell(o_busy));
    c_toggle: cover property (rvalid && rdata[TOGGLE_BIT]);
    c_refuse: cover property (o_ser_reject);
endmodule

//--- testbench/flash_command_sequencer_tb_top.sv
/*
 * Bench: the CPU sequencer drives one controller, the bench drives a
 * second controller directly. Assumes the package and design compiled first.
 */
`timescale 1ns/1ps
module flash_command_sequencer_tb_top;
    import flash_seq_pkg::*;
    localparam int         ERASE_SIM = 50;     // Short erase keeps the run brief
    localparam int         MAX_CYC   = 40000;  // Hang ceiling
    localparam logic [7:0] VENDOR_ID = 8'h21;  // Arbitrary value
    localparam logic [7:0] FLASH_ID  = 8'h43;  // Arbitrary value
    logic        clock, rst, start, slow, par, ser;
    logic [2:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        done, cpu_busy, busy_a, prot_a, rej_a, id_a, busy_b, prot_b, id_b;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    flash_seq_if bus_a ();
    flash_seq_if bus_b ();

    // Both ends of the first bus, plus a bench-driven controller
    flash_seq_cpu u_flash_seq_cpu (.i_clock(clock), .i_rst(rst), .i_start(start), .i_cmd(cmd),
        .i_addr(addr), .i_data(data), .o_done(done), .o_busy(cpu_busy), .bus(bus_a));
    flash_seq_ctrl #(.ERASE_CYCLES(ERASE_SIM)) u_flash_seq_ctrl (.i_clock(clock), .i_rst(rst),
        .bus(bus_a), .i_slow_mode(slow), .i_par_prog(par), .i_ser_overwr(ser), .o_busy(busy_a),
        .o_protected(prot_a), .o_ser_reject(rej_a), .o_id_mode(id_a));
    flash_seq_ctrl #(.ERASE_CYCLES(ERASE_SIM), .VENDOR_CODE(VENDOR_ID), .FLASH_CODE(FLASH_ID))
        u_flash_seq_ctrl_2 (.i_clock(clock), .i_rst(rst), .bus(bus_b), .i_slow_mode(slow),
        .i_par_prog(par), .i_ser_overwr(ser), .o_busy(busy_b), .o_protected(prot_b),
        .o_ser_reject(), .o_id_mode(id_b));
    flash_seq_properties #(.ERASE_CYCLES(ERASE_SIM)) u_flash_seq_properties (.i_clock(clock),
        .i_rst(rst), .wr(bus_a.wr), .rd(bus_a.rd), .wide(bus_a.wide), .addr(bus_a.addr),
        .wdata(bus_a.wdata), .rdata(bus_a.rdata), .rvalid(bus_a.rvalid), .cw_wr(bus_a.cw_wr),
        .cw_sel(bus_a.cw_sel), .cw_data(bus_a.cw_data), .o_busy(busy_a), .o_protected(prot_a),
        .i_ser_overwr(ser), .o_ser_reject(rej_a));

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == MAX_CYC) begin
            n_mismatch++;
            $display("Run cut short at cycle %0d", cycles);
            conclude();
        end
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bench bus strobes last one cycle, with an idle cycle after each
    task automatic b_wr(input logic c, input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        bus_b.wr = !c;
        bus_b.cw_wr = c;
        bus_b.cw_sel = a[0];
        bus_b.addr = a;
        bus_b.wdata = d;
        bus_b.cw_data = d;
        @(negedge clock);
        bus_b.wr = 1'b0;
        bus_b.cw_wr = 1'b0;
    endtask

    task automatic b_mode(input logic [2:0] m);
        b_wr(1'b1, 16'h0000, {m, 5'h00});
        b_wr(1'b1, 16'h0001, COMMIT_KEY);
    endtask

    task automatic b_key(input logic [7:0] c);
        b_wr(1'b0, KEY_ADDR_A, KEY_DATA_A);
        b_wr(1'b0, KEY_ADDR_B, KEY_DATA_B);
        b_wr(1'b0, KEY_ADDR_A, c);
    endtask

    // Six-write sequences: erase and security
    task automatic b_key6(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
        b_key(c);
        b_wr(1'b0, KEY_ADDR_A, KEY_DATA_A);
        b_wr(1'b0, KEY_ADDR_B, KEY_DATA_B);
        b_wr(1'b0, a, d);
    endtask

    task automatic b_rd(input string nm, input logic [15:0] a, input logic [7:0] e);
        @(negedge clock);
        bus_b.rd = 1'b1;
        bus_b.addr = a;
        @(negedge clock);
        bus_b.rd = 1'b0;
        chk("read valid", 8'h01, {7'h00, bus_b.rvalid});
        chk(nm, e, bus_b.rdata);
    endtask

    task automatic b_idle(input int lim);
        int n;
        n = 0;
        while (busy_b !== 1'b0 && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk("idle in time", 8'h00, {7'h00, busy_b});
    endtask

    task automatic cpu_run(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(negedge clock);
        cmd = c;
        addr = a;
        data = d;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 6000) begin
            @(negedge clock);
            n++;
        end
        chk("cpu done", 8'h01, {7'h00, done});
    endtask

    task automatic t_cpu_path;
        // Clear the unknown array first
        cpu_run(3'd2, 16'h8000, 8'h00);
        cpu_run(3'd3, 16'hF000, 8'h00);
        chk("protect set", 8'h01, {7'h00, prot_a});
        ser = 1'b1;
        @(negedge clock);
        chk("loader refused", 8'h01, {7'h00, rej_a});
        ser = 1'b0;
        cpu_run(3'd4, 16'hF000, 8'h00);
        chk("cpu id mode", 8'h01, {7'h00, id_a});
        cpu_run(3'd5, 16'hF000, 8'h00);
        chk("cpu id left", 8'h00, {7'h00, id_a});
        chk("protect kept", 8'h01, {7'h00, prot_a});
        cpu_run(3'd2, 16'h8000, 8'h00);
        chk("protect cleared", 8'h00, {7'h00, prot_a});
        cpu_run(3'd0, 16'h8100, 8'h3C);
        cpu_run(3'd1, 16'h8000, 8'h00);
        chk("cpu idle", 8'h00, {7'h00, cpu_busy});
        $display("t_cpu_path done");
    endtask

    task automatic t_erase_toggle;
        b_mode(MODE_ENABLE);
        b_key6(CMD_ERASE_PRE, 16'h8000, CMD_CHIP);
        b_rd("first poll", 16'h8000, 8'h40);
        b_rd("second poll", 16'h8000, 8'h00);
        b_key(CMD_PROGRAM);
        b_wr(1'b0, 16'h8200, 8'h00);
        b_idle(ERASE_SIM + 10);
        b_rd("erased byte", 16'h8200, ERASED_BYTE);
        $display("t_erase_toggle done");
    endtask

    task automatic t_slow_disable;
        slow = 1'b1;
        b_key(CMD_PROGRAM);
        b_wr(1'b0, 16'h8300, 8'h3C);
        b_rd("slow program", 16'h8300, 8'h3C);
        slow = 1'b0;
        b_key6(CMD_ERASE_PRE, 16'h9000, CMD_SECTOR);
        b_wr(1'b1, 16'h0000, {MODE_DISABLE, 5'h00});
        b_rd("steady a", 16'h9000, 8'h00);
        b_rd("steady b", 16'h9000, 8'h00);
        b_idle(ERASE_SIM + 10);
        b_wr(1'b1, 16'h0001, COMMIT_KEY);
        b_key(CMD_PROGRAM);
        b_wr(1'b0, 16'h8400, 8'h00);
        chk("disabled idle", 8'h00, {7'h00, busy_b});
        b_rd("disabled read", 16'h8400, ERASED_BYTE);
        b_mode(MODE_ENABLE);
        $display("t_slow_disable done");
    endtask

    task automatic t_id_secure;
        b_key(CMD_ID_ENTRY);
        chk("id mode", 8'h01, {7'h00, id_b});
        b_rd("vendor", ID_VENDOR_ADR, VENDOR_ID);
        b_rd("flash code", ID_FLASH_ADR, FLASH_ID);
        b_rd("security off", ID_SECUR_ADR, SECUR_OFF);
        b_key(CMD_ID_EXIT);
        b_rd("after exit", ID_VENDOR_ADR, ERASED_BYTE);
        b_key6(CMD_SECURITY, 16'h8000, 8'h00);
        b_rd("security poll", 16'h8000, 8'h40);
        b_idle(SECUR_CYC + 20);
        chk("protect on", 8'h01, {7'h00, prot_b});
        b_key(CMD_ID_ENTRY);
        b_rd("security on", ID_SECUR_ADR, SECUR_ON);
        b_key(CMD_ID_EXIT);
        par = 1'b1;
        b_rd("parallel blocked", 16'h8300, 8'h00);
        par = 1'b0;
        b_rd("parallel free", 16'h8300, 8'h3C);
        $display("t_id_secure done");
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {start, slow, par, ser} = 4'h0;
        {cmd, addr, data} = 27'h000_0000;
        {bus_b.wr, bus_b.rd, bus_b.wide, bus_b.cw_wr, bus_b.cw_sel} = 5'h00;
        {bus_b.addr, bus_b.wdata, bus_b.cw_data} = 32'h0000_0000;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        t_cpu_path;
        t_erase_toggle;
        t_slow_disable;
        t_id_secure;
        conclude;
    end
endmodule
